// ==== rtl/tpc_timer.v ====
// Timer/PWM module with eight capture, compare and PWM channels
`timescale 1ns/10ps
`include "tpc_map.vh"

module tpc_timer (
  input wire mclk, // Bus clock
  input wire rst_n, // Synchronous reset, active low
  input wire clk_en, // Low freezes all state, as in stop mode
  input wire [7:0] addr, // Register word address
  input wire [15:0] wdata, // Write data
  input wire wr_en, // Write strobe, one cycle
  input wire rd_en, // Read strobe, one cycle
  output reg [15:0] rdata, // Read data, one cycle after rd_en
  input wire background_debug_mode, // High holds counter and prescaler
  input wire fixed_clk, // Slow fixed clock, foreign domain
  input wire external_count_clock, // Pin clock, foreign domain
  input wire [7:0] timer_channel_pin_in, // Pin levels, foreign domain
  output wire [7:0] timer_channel_pin_out, // Driven pin levels
  output wire [7:0] timer_channel_pin_oe // High while the timer drives
);

  // Prescaler hit: low 'sel' bits all ones (divide by 2**sel)
  // A select of zero gives an empty mask, so every event hits;
  // the widest select needs all seven prescaler bits set.
  function pre_hit;
    input [6:0] cnt;
    input [2:0] sel;
    reg [6:0] mask;
    begin
      mask = ~(7'h7F << sel);
      pre_hit = ((cnt & mask) == mask);
    end
  endfunction

  // Software registers
  reg [15:0] ctrl_ff; // Clock select, prescale, center mode
  reg [15:0] mod_ff; // Modulo value
  reg [15:0] cnt_ff; // Counter
  reg dir_down_ff; // Center mode count direction
  reg [6:0] pre_ff; // Prescaler
  reg [7:0] chflag_ff; // Channel flags
  reg tof_ff; // Terminal count flag
  reg [3:0] chcfg_ff [0:7]; // Channel mode and level
  reg [15:0] chval_ff [0:7]; // Channel value
  reg [7:0] pin_ff; // Driven channel levels

  // Three-stage synchronisers for every foreign input
  // The first stage may go metastable, so only the second reads it;
  // a level is accepted once stages 2 and 3 agree, which costs
  // three to four cycles of capture latency.
  reg [9:0] sy1_ff; // First stage, read only by second
  reg [9:0] sy2_ff; // Second stage
  reg [9:0] sy3_ff; // Third stage
  reg [9:0] st_ff; // Accepted level, changes when 2 and 3 agree

  wire [9:0] raw_in;
  wire [9:0] agree;
  wire [9:0] rise;
  wire [9:0] fall;

  // Bits 7:0 channel pins, 8 fixed clock, 9 external clock
  assign raw_in = {external_count_clock, fixed_clk,
    timer_channel_pin_in};
  assign agree = ~(sy2_ff ^ sy3_ff);
  assign rise = agree & sy3_ff & ~st_ff;
  assign fall = agree & ~sy3_ff & st_ff;

  // Control fields
  wire [1:0] clk_sel;
  wire [2:0] pre_sel;
  wire center_aligned_pwm_on;
  assign clk_sel = ctrl_ff[`TPC_CLK_HI:`TPC_CLK_LO];
  assign pre_sel = ctrl_ff[`TPC_PRE_HI:`TPC_PRE_LO];
  assign center_aligned_pwm_on = ctrl_ff[`TPC_CENTER_ALIGNED_PWM_BIT];

  // Address decode
  // Channel words are paired: even word is config, odd is value
  wire in_ch;
  wire [2:0] ch_idx;
  wire ch_is_val;
  wire wr_ctrl;
  wire wr_cnt;
  wire wr_mod;
  wire wr_flags;
  assign in_ch = (addr >= `TPC_A_CH_BASE) && (addr <= `TPC_A_CH_LAST);
  assign ch_idx = addr[3:1];
  assign ch_is_val = addr[0];
  assign wr_ctrl = wr_en && (addr == `TPC_A_CTRL);
  assign wr_cnt = wr_en && (addr == `TPC_A_COUNT);
  assign wr_mod = wr_en && (addr == `TPC_A_MOD);
  assign wr_flags = wr_en && (addr == `TPC_A_FLAGS);

  // Source event selection before the prescaler
  // Slow sources count on their synchronised rising edge only; the
  // far side must keep them under a quarter of the bus rate.
  reg src_evt;
  always @* begin
    case (clk_sel)
      `TPC_CLK_BUS: src_evt = 1'b1;
      `TPC_CLK_FIX: src_evt = rise[8];
      `TPC_CLK_EXT: src_evt = rise[9];
      default: src_evt = 1'b0;
    endcase
  end

  // Counter advances only outside debug halt
  // Debug gates prescaler and counter alike, so counting resumes
  // exactly where it stopped once debug ends.
  wire running;
  wire tick;
  assign running = (clk_sel != `TPC_CLK_OFF);
  assign tick = running && src_evt && pre_hit(pre_ff, pre_sel) &&
    !background_debug_mode;

  // Both extreme modulo values mean free-running
  wire mod_free;
  wire [15:0] top;
  assign mod_free = (mod_ff == `TPC_CNT_RST) ||
    (mod_ff == `TPC_CNT_MAX);
  assign top = mod_free ? `TPC_CNT_MAX : mod_ff;

  // Next count and direction on a tick
  // Up mode visits 0..top; center mode visits 0..top..1, so its
  // period is twice the top value and zero is seen once per period.
  reg [15:0] nxt_cnt;
  reg nxt_dir_down;
  reg wrap;
  always @* begin
    nxt_cnt = cnt_ff;
    nxt_dir_down = dir_down_ff;
    wrap = 1'b0;
    if (!center_aligned_pwm_on) begin
      nxt_dir_down = 1'b0;
      if (cnt_ff >= top) begin
        // Wrap to zero after the modulo value
        nxt_cnt = `TPC_CNT_RST;
        wrap = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else if (!dir_down_ff) begin
      // Up leg ends at the modulo value
      if (cnt_ff >= top) begin
        nxt_cnt = cnt_ff - 16'h0001;
        nxt_dir_down = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end else begin
      // Down leg ends at zero, which closes the period
      if (cnt_ff == `TPC_CNT_RST) begin
        nxt_cnt = 16'h0001;
        nxt_dir_down = 1'b0;
        wrap = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 16'h0001;
      end
    end
  end

  // Per-channel pin actions, flag sets and captures
  // Matches use the count about to be loaded, so pin changes and
  // flags line up with the counter edge itself.
  // In edge PWM a duty match beats the period start, giving zero
  // duty for a value of zero.
  reg [7:0] nxt_pin;
  reg [7:0] ch_set;
  reg [7:0] cap_hit;
  reg [7:0] drive;
  integer i;
  always @* begin
    nxt_pin = pin_ff;
    ch_set = 8'h00;
    cap_hit = 8'h00;
    drive = 8'h00;
    for (i = 0; i < `TPC_NCH; i = i + 1) begin
      if (center_aligned_pwm_on) begin
        // Center mode overrides every channel mode
        if (chcfg_ff[i][`TPC_LVL_HI:`TPC_LVL_LO] != `TPC_LVL_OFF) begin
          drive[i] = running;
          if (tick && nxt_cnt == chval_ff[i]) begin
            ch_set[i] = 1'b1;
            // Down match turns on, up match turns off
            nxt_pin[i] = nxt_dir_down ^
              chcfg_ff[i][`TPC_LVL_LO];
          end
        end
      end else if (chcfg_ff[i][`TPC_MODE_HI:`TPC_MODE_LO] ==
                   `TPC_MODE_CAP) begin
        // Input capture; pin stays an input
        case (chcfg_ff[i][`TPC_LVL_HI:`TPC_LVL_LO])
          2'h1: cap_hit[i] = rise[i];
          2'h2: cap_hit[i] = fall[i];
          2'h3: cap_hit[i] = rise[i] | fall[i];
          default: cap_hit[i] = 1'b0;
        endcase
        cap_hit[i] = cap_hit[i] & running;
        ch_set[i] = cap_hit[i];
      end else if (chcfg_ff[i][`TPC_MODE_HI:`TPC_MODE_LO] ==
                   `TPC_MODE_CMP) begin
        // Output compare; level 0 means software timing only
        if (chcfg_ff[i][`TPC_LVL_HI:`TPC_LVL_LO] != `TPC_LVL_OFF) begin
          drive[i] = running;
        end
        if (tick && nxt_cnt == chval_ff[i]) begin
          ch_set[i] = 1'b1;
          case (chcfg_ff[i][`TPC_LVL_HI:`TPC_LVL_LO])
            2'h1: nxt_pin[i] = ~pin_ff[i];
            2'h2: nxt_pin[i] = 1'b0;
            2'h3: nxt_pin[i] = 1'b1;
            default: nxt_pin[i] = pin_ff[i];
          endcase
        end
      end else begin
        // Edge PWM; level bit 0 picks low-true pulse
        if (chcfg_ff[i][`TPC_LVL_HI:`TPC_LVL_LO] != `TPC_LVL_OFF) begin
          drive[i] = running;
          if (tick && nxt_cnt == `TPC_CNT_RST) begin
            // Leading edge at period start
            nxt_pin[i] = ~chcfg_ff[i][`TPC_LVL_LO];
          end
          if (tick && nxt_cnt == chval_ff[i]) begin
            // Duty end; a zero value yields zero duty
            nxt_pin[i] = chcfg_ff[i][`TPC_LVL_LO];
            ch_set[i] = 1'b1;
          end
        end
      end
    end
  end

  // Pins revert to port logic when the timer does not use them
  // The level is masked by the enable so a released pin never
  // shows a stale level to the port logic.
  assign timer_channel_pin_oe = drive;
  assign timer_channel_pin_out = pin_ff & drive;

  // Synchronisers; all state frozen while clk_en is low
  // Stages reset low: a pin held high then shows one rise, which is
  // harmless as no channel can capture until it is configured.
  always @(posedge mclk) begin
    if (!rst_n) begin
      sy1_ff <= 10'h000;
      sy2_ff <= 10'h000;
      sy3_ff <= 10'h000;
      st_ff <= 10'h000;
    end else if (clk_en) begin
      sy1_ff <= raw_in;
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      // Accept a new level only when stages 2 and 3 agree
      st_ff <= (st_ff & ~agree) | (sy3_ff & agree);
    end
  end

  // Counter, prescaler and global flags
  // A count write also restarts prescaler and up direction, so the
  // first tick after it always comes a full division later.
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_ff <= `TPC_CTRL_RST;
      mod_ff <= `TPC_MOD_RST;
      cnt_ff <= `TPC_CNT_RST;
      dir_down_ff <= 1'b0;
      pre_ff <= 7'h00;
      tof_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_ff <= {10'h000, wdata[5:0]};
      end
      if (wr_mod) begin
        mod_ff <= wdata;
      end
      if (wr_cnt) begin
        // Any data value clears counter and prescaler
        cnt_ff <= `TPC_CNT_RST;
        dir_down_ff <= 1'b0;
        pre_ff <= 7'h00;
      end else begin
        // Wait mode needs no gating here at all
        if (running && src_evt && !background_debug_mode) begin
          pre_ff <= pre_ff + 7'h01;
        end
        if (tick) begin
          cnt_ff <= nxt_cnt;
          dir_down_ff <= nxt_dir_down;
        end
      end
      // Set beats a simultaneous write-one clear
      tof_ff <= (tick && wrap && !wr_cnt) |
        (tof_ff & ~(wr_ctrl & wdata[`TPC_TOF_BIT]));
    end
  end

  // Channel registers, pins and flags
  // A capture wins over a same-cycle value write; losing a
  // timestamp would be worse than losing a software write.
  integer k;
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin_ff <= 8'h00;
      chflag_ff <= 8'h00;
      for (k = 0; k < `TPC_NCH; k = k + 1) begin
        chcfg_ff[k] <= `TPC_CHCFG_RST;
        chval_ff[k] <= `TPC_CNT_RST;
      end
    end else if (clk_en) begin
      pin_ff <= nxt_pin;
      // Flag set wins over a same-cycle clear
      chflag_ff <= ch_set |
        (chflag_ff & ~(wr_flags ? wdata[7:0] : 8'h00));
      for (k = 0; k < `TPC_NCH; k = k + 1) begin
        if (cap_hit[k]) begin
          // Capture has priority over a software write
          chval_ff[k] <= cnt_ff;
        end else if (wr_en && in_ch && ch_is_val &&
                     ch_idx == k[2:0]) begin
          chval_ff[k] <= wdata;
        end
        if (wr_en && in_ch && !ch_is_val && ch_idx == k[2:0]) begin
          chcfg_ff[k] <= wdata[3:0];
        end
      end
    end
  end

  // Read port: data valid in the cycle after rd_en only
  // Reads only copy state, so software may poll the counter freely;
  // idle zero keeps stale data from looking like a fresh answer.
  always @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      if (!rd_en) begin
        rdata <= 16'h0000;
      end else if (in_ch) begin
        rdata <= ch_is_val ? chval_ff[ch_idx] :
          {12'h000, chcfg_ff[ch_idx]};
      end else begin
        case (addr)
          `TPC_A_CTRL: rdata <= {9'h000, tof_ff, ctrl_ff[5:0]};
          `TPC_A_COUNT: rdata <= cnt_ff;
          `TPC_A_MOD: rdata <= mod_ff;
          `TPC_A_FLAGS: rdata <= {8'h00, chflag_ff};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// ==== inc/tpc_map.vh ====
// Register map, field positions and reset values of the timer module
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// Channel count, fixed at the largest documented size
`define TPC_NCH 8
// Counter width
`define TPC_CW 16

// Register word addresses
`define TPC_A_CTRL 8'h00
`define TPC_A_COUNT 8'h01
`define TPC_A_MOD 8'h02
`define TPC_A_FLAGS 8'h03
// Channel n config at base+2n, value at base+2n+1
`define TPC_A_CH_BASE 8'h10
`define TPC_A_CH_LAST 8'h1F

// Control register fields
`define TPC_CLK_LO 0
`define TPC_CLK_HI 1
`define TPC_PRE_LO 2
`define TPC_PRE_HI 4
`define TPC_CENTER_ALIGNED_PWM_BIT 5
`define TPC_TOF_BIT 6
`define TPC_CTRL_RST 16'h0000

// Clock source select codes
`define TPC_CLK_OFF 2'h0
`define TPC_CLK_BUS 2'h1
`define TPC_CLK_FIX 2'h2
`define TPC_CLK_EXT 2'h3

// Channel config fields: mode [1:0], edge or level [3:2]
`define TPC_MODE_LO 0
`define TPC_MODE_HI 1
`define TPC_LVL_LO 2
`define TPC_LVL_HI 3
`define TPC_MODE_CAP 2'h0
`define TPC_MODE_CMP 2'h1
`define TPC_LVL_OFF 2'h0
`define TPC_CHCFG_RST 4'h0

// Counter and modulo reset values, free-running extremes
`define TPC_CNT_RST 16'h0000
`define TPC_MOD_RST 16'h0000
`define TPC_CNT_MAX 16'hFFFF

`endif

// ==== bench/tpc_timer_monitor.sv ====
// Port checker for the timer module
`timescale 1ns/10ps
module tpc_timer_monitor (
  input wire mclk,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_en,
  input wire rd_en,
  input wire [15:0] rdata,
  input wire background_debug_mode,
  input wire [7:0] timer_channel_pin_out,
  input wire [7:0] timer_channel_pin_oe
);
  // One clock domain, so one clocking and one reset for all
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Read data stand only in the cycle after a taken read
  rdata_idle_a: assert property (
    clk_en && !rd_en |=> rdata == 16'h0000) else $error("rdata not idle");
  // A pin is never driven high unless the timer owns it
  pin_gate_a: assert property (
    (timer_channel_pin_out & ~timer_channel_pin_oe) == 8'h00)
    else $error("pin driven while released");
  // Leaving reset, every pin is back with the port logic
  reset_quiet_a: assert property (
    $rose(rst_n) |-> timer_channel_pin_oe == 8'h00 && rdata == 16'h0000)
    else $error("not quiet after reset");
  // Stop mode: no output may move while the clock enable is low
  stop_freeze_a: assert property (
    !clk_en |=> $stable(timer_channel_pin_out) &&
    $stable(timer_channel_pin_oe) && $stable(rdata))
    else $error("moved in stop mode");
  // Two count reads in debug see the same value
  debug_hold_a: assert property (
    (rd_en && clk_en && background_debug_mode && addr == 8'h01)[*2]
    |=> $stable(rdata)) else $error("count moved in debug");
  // A count write leaves at most one tick on the next read
  count_clear_a: assert property (
    wr_en && clk_en && addr == 8'h01 ##1 rd_en && clk_en && addr == 8'h01
    |=> rdata <= 16'h0001) else $error("count not cleared");
  // Clock source off hands every pin back at once
  clk_off_a: assert property (
    wr_en && clk_en && addr == 8'h00 && wdata[1:0] == 2'h0
    |=> timer_channel_pin_oe == 8'h00) else $error("pin kept when off");
  // Modulo reads back what was written
  mod_store_a: assert property (
    wr_en && clk_en && addr == 8'h02 ##1 rd_en && clk_en && addr == 8'h02
    |=> rdata == $past(wdata, 2)) else $error("modulo not stored");
endmodule

// ==== bench/tpc_pins.sv ====
// Far-side pin model: loads, capture sources and slow count clocks
`timescale 1ns/10ps
module tpc_pins (
  input wire mclk,
  input wire [7:0] stim,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe,
  output wire [7:0] pin_in,
  output reg fix_clk_ff,
  output reg ext_clk_ff
);
  reg [2:0] div_ff = 3'h0; // Divider shared by both clocks
  // A driven pin reads back the timer, a released one the source
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & stim);
  initial fix_clk_ff = 1'b0;
  initial ext_clk_ff = 1'b0;
  // Both clocks stay well under a quarter of the bus rate
  always @(posedge mclk) begin
    div_ff <= div_ff + 3'h1;
    if (div_ff[1:0] == 2'h3) ext_clk_ff <= ~ext_clk_ff;
    if (div_ff == 3'h7) fix_clk_ff <= ~fix_clk_ff;
  end
endmodule

// ==== bench/timer_pwm_capture_compare_test.sv ====
// Self-checking bench of the timer module
`timescale 1ns/10ps
`include "tpc_map.vh"
module timer_pwm_capture_compare_test;
  logic mclk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, wr_en = 1'b0;
  logic rd_en = 1'b0, background_debug_mode = 1'b0, fixed_clk;
  logic external_count_clock;
  logic [7:0] addr = 8'h00, stim = 8'h00, pin_in, pin_out, pin_oe;
  logic [15:0] wdata = 16'h0000, rdata, prev, a;
  logic [31:0] seed = 32'd92316; // Fixed seed keeps runs repeatable
  logic [15:0] srcs [4] = '{16'h0001, 16'h0005, 16'h0003, 16'h0002};
  int mul [4] = '{1, 2, 8, 16}; // Cycles per tick of each source
  int cmpx [4] = '{0, 20, 0, 40}; // High cycles per compare action
  int err_count = 0, n_compared = 0, hi, i, j, ch, m, v, t, h;
  bit c, p;
  always #4 mclk = ~mclk;
  tpc_timer uut (.mclk, .rst_n, .clk_en, .addr, .wdata, .wr_en, .rd_en,
    .rdata, .background_debug_mode, .fixed_clk, .external_count_clock,
    .timer_channel_pin_in(pin_in), .timer_channel_pin_out(pin_out),
    .timer_channel_pin_oe(pin_oe));
  tpc_pins far (.mclk, .stim, .pin_out, .pin_oe, .pin_in,
    .fix_clk_ff(fixed_clk), .ext_clk_ff(external_count_clock));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, exp, input string s);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s", $time, s);
    end
  endtask
  // One bus cycle: 0 idle, 1 read, 2 write; prev gets the last read
  task automatic bus(input logic [1:0] k, input logic [7:0] ad,
    input logic [15:0] d);
    addr <= ad;
    wdata <= d;
    wr_en <= k[1];
    rd_en <= k[0];
    @(negedge mclk) prev = rdata;
    @(posedge mclk);
  endtask
  // Count cycles with the pin high, sampled mid-cycle
  task automatic meas(input int n);
    hi = 0;
    wr_en <= 1'b0; // Strobes last one cycle only
    rd_en <= 1'b0;
    repeat (n) begin
      @(negedge mclk) hi += pin_out[ch];
      @(posedge mclk);
    end
  endtask
  // Stop first so a shorter modulo never strands the counter
  task automatic setup(input logic [15:0] cfg, val, input int md);
    bus(2, `TPC_A_CTRL, 16'h0040);
    bus(2, `TPC_A_FLAGS, 16'h00FF);
    bus(2, `TPC_A_MOD, md[15:0]);
    bus(2, 8'(`TPC_A_CH_BASE + 2 * ch), cfg);
    bus(2, 8'(`TPC_A_CH_BASE + 2 * ch + 1), val);
    bus(2, `TPC_A_COUNT, 16'(rnd()));
  endtask
  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    err_count++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    bus(0, 0, 0);
    bus(1, `TPC_A_CTRL, 0);
    bus(1, 8'h05, 0);
    chk(prev, `TPC_CTRL_RST, "ctrl reset");
    bus(0, 0, 0);
    chk(prev, 0, "unmapped read");
    // Edge then center PWM over every clock source, random polarity
    for (i = 0; i < 8; i++) begin
      ch = rnd() % 8;
      c = i / 4;
      p = rnd() % 2;
      m = 3 + rnd() % 4;
      v = 1 + rnd() % (m - c);
      t = c ? 2 * m : m + 1;
      h = c ? 2 * v : v;
      setup(p ? 16'h0006 : 16'h000A, 16'(v), m);
      bus(2, `TPC_A_CTRL, srcs[i % 4] | (c ? 16'h0020 : 16'h0000));
      meas(t * mul[i % 4]);
      meas(2 * t * mul[i % 4]);
      chk(hi, 2 * mul[i % 4] * (p ? t - h : h), "pwm");
      bus(1, `TPC_A_CTRL, 0);
      bus(1, `TPC_A_FLAGS, 0);
      chk(prev[`TPC_TOF_BIT], 1, "period flag");
      bus(0, 0, 0);
      chk(prev[ch], 1, "duty flag");
    end
    // Compare actions: none, toggle, clear, set
    for (j = 0; j < 4; j++) begin
      ch = rnd() % 8;
      setup(16'(4 * j + 1), 16'(rnd() % 10), 9);
      bus(2, `TPC_A_CTRL, 16'h0001);
      meas(10);
      bus(2, `TPC_A_FLAGS, 16'h00FF);
      meas(40);
      chk(hi, cmpx[j], "compare pin");
      chk(pin_oe[ch], j != 0, "compare drive");
      bus(1, `TPC_A_FLAGS, 0);
      bus(0, 0, 0);
      chk(prev[ch], 1, "compare flag");
    end
    // Capture edges: none, rising, falling, both
    for (j = 0; j < 4; j++) begin
      ch = rnd() % 8;
      setup(16'(4 * j), 16'h0000, 0);
      bus(2, `TPC_A_CTRL, 16'h0001);
      meas(8);
      bus(2, `TPC_A_FLAGS, 16'h00FF);
      stim[ch] <= 1'b1;
      meas(8);
      bus(1, `TPC_A_FLAGS, 0);
      bus(2, `TPC_A_FLAGS, 16'h00FF);
      chk(prev[ch], j % 2, "rise capture");
      stim[ch] <= 1'b0;
      meas(8);
      bus(1, `TPC_A_FLAGS, 0);
      bus(1, 8'(`TPC_A_CH_BASE + 2 * ch + 1), 0);
      chk(prev[ch], j >= 2, "fall capture");
      bus(1, `TPC_A_COUNT, 0);
      a = prev;
      bus(0, 0, 0);
      chk(16'(prev - a) < 16'd12, j >= 2, "capture value");
    end
    // Debug holds the count; outside it, reads a cycle apart see it step by one
    background_debug_mode <= 1'b1;
    bus(1, `TPC_A_COUNT, 0);
    bus(1, `TPC_A_COUNT, 0);
    a = prev;
    background_debug_mode <= 1'b0;
    bus(1, `TPC_A_COUNT, 0);
    chk(prev, a, "debug hold");
    bus(1, `TPC_A_COUNT, 0);
    a = prev;
    bus(0, 0, 0);
    chk(prev, 16'(a + 1), "read step");
    // Stop mode freezes the count for four cycles
    bus(1, `TPC_A_COUNT, 0);
    clk_en <= 1'b0;
    bus(0, 0, 0);
    a = prev;
    repeat (3) bus(0, 0, 0);
    clk_en <= 1'b1;
    bus(1, `TPC_A_COUNT, 0);
    bus(2, `TPC_A_COUNT, 16'(rnd()));
    chk(prev, 16'(a + 1), "stop freeze");
    bus(1, `TPC_A_COUNT, 0);
    bus(0, 0, 0);
    chk(prev <= 16'h0001, 1, "count clear");
    // Mid-run reset hands every pin back and clears the control word
    setup(16'h000A, 16'h0002, 5);
    bus(2, `TPC_A_CTRL, 16'h0001);
    meas(8);
    chk(pin_oe[ch], 1, "pin owned");
    rst_n <= 1'b0;
    repeat (2) bus(0, 0, 0);
    rst_n <= 1'b1;
    bus(0, 0, 0);
    chk(pin_oe, 0, "pins after reset");
    bus(1, `TPC_A_CTRL, 0);
    a = 16'(rnd());
    bus(2, `TPC_A_MOD, a);
    chk(prev, `TPC_CTRL_RST, "ctrl after reset");
    bus(1, `TPC_A_MOD, 0);
    bus(0, 0, 0);
    chk(prev, a, "modulo store");
    finish_test();
  end
endmodule
bind tpc_timer tpc_timer_monitor mon (.mclk, .rst_n, .clk_en, .addr, .wdata,
  .wr_en, .rd_en, .rdata, .background_debug_mode, .timer_channel_pin_out,
  .timer_channel_pin_oe);
